// file: hw/kbu_defines.vh
`ifndef KBU_DEFINES_VH
`define KBU_DEFINES_VH
// ==========================================================
// Register map
`define KBU_ADDR_W          5
`define KBU_OFF_STATUS_CTRL 5'h16
`define KBU_OFF_PIN_ENABLE  5'h17
`define KBU_OFF_BREAK_CTRL  5'h18
// ==========================================================
// Status and control fields
`define KBU_BIT_SENS        0
`define KBU_BIT_MASK        1
`define KBU_BIT_ACK         2
`define KBU_BIT_PEND        3
// ==========================================================
// Break control fields
`define KBU_BIT_BCLR_EN     0
// ==========================================================
// Reset values
`define KBU_RST_STATUS_CTRL 8'h00
`define KBU_RST_PIN_ENABLE  8'h00
`endif

// file: hw/kbu_keyboard_unit.v
// The implementer's own choice: strobed register access.
`include "kbu_defines.vh"
`default_nettype none

module kbu_keyboard_unit (
   // Clock and reset
   input  wire                     clk_sys_i,
   input  wire                     rst_n_i,
   // Register port
   input  wire [`KBU_ADDR_W-1:0]   reg_addr_i,
   input  wire [7:0]               reg_wdata_i,
   input  wire                     reg_wr_i,
   input  wire                     reg_rd_i,
   output reg  [7:0]               reg_rdata_o,
   // Key pins and port control
   input  wire [7:0]               key_inputs_i,
   input  wire [7:0]               port_a_direction_i,
   output reg  [7:0]               key_pullup_en_o,
   output reg  [7:0]               key_dir_out_o,
   // CPU side
   input  wire                     vector_fetch_ack_i,
   input  wire                     break_state_i,
   output reg                      kbd_irq_o,
   output reg                      wake_o
);

   // ==========================================================
   // Registers
   reg  [7:0] pin_enable_q;
   reg        request_mask_q;
   reg        sensitivity_select_q;
   reg        break_clear_enable_q;
   reg        pending_q;
   reg        pending_d;
   reg        ack_seen_q;
   reg        ack_seen_d;
   reg  [7:0] key_sync1_q;
   reg  [7:0] key_sync2_q;
   reg        all_high_prev_q;

   wire wr_sc   = reg_wr_i && (reg_addr_i == `KBU_OFF_STATUS_CTRL);
   wire wr_pe   = reg_wr_i && (reg_addr_i == `KBU_OFF_PIN_ENABLE);
   wire wr_brk  = reg_wr_i && (reg_addr_i == `KBU_OFF_BREAK_CTRL);

   // ==========================================================
   // Pin synchroniser, only the second stage is looked at
   always @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         key_sync1_q <= 8'hFF;
         key_sync2_q <= 8'hFF;
      end else begin
         key_sync1_q <= key_inputs_i;
         key_sync2_q <= key_sync1_q;
      end
   end

   // Any enabled pin low; disabled pins count as high
   wire any_low  = |(pin_enable_q & ~key_sync2_q);
   // Fall from the all-high state is the only way to latch
   wire fall_evt = any_low && all_high_prev_q;
   // Software ack, suppressed in break unless clearing is allowed
   wire sw_ack   = wr_sc && reg_wdata_i[`KBU_BIT_ACK] &&
                   (!break_state_i || break_clear_enable_q);
   wire ack      = sw_ack || vector_fetch_ack_i;

   // ==========================================================
   // Request latch; a new fall beats a same-cycle ack
   // Level mode remembers an early ack, so pins going high later still clear
   always @* begin
      pending_d  = pending_q;
      ack_seen_d = ack_seen_q;
      if (ack) begin
         if (sensitivity_select_q && any_low && pending_q) begin
            ack_seen_d = 1'b1;
         end else begin
            pending_d  = 1'b0;
            ack_seen_d = 1'b0;
         end
      end
      if (sensitivity_select_q && ack_seen_q && !any_low) begin
         pending_d  = 1'b0;
         ack_seen_d = 1'b0;
      end
      if (!sensitivity_select_q) begin
         ack_seen_d = 1'b0;
      end
      if (fall_evt) begin
         pending_d  = 1'b1;
         ack_seen_d = 1'b0;
      end
   end

   // ==========================================================
   // Control registers and latch state
   always @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         pin_enable_q         <= `KBU_RST_PIN_ENABLE;
         request_mask_q       <= 1'b0;
         sensitivity_select_q <= 1'b0;
         break_clear_enable_q <= 1'b0;
         pending_q            <= 1'b0;
         ack_seen_q           <= 1'b0;
         all_high_prev_q      <= 1'b1;
      end else begin
         if (wr_pe) begin
            pin_enable_q <= reg_wdata_i;
         end
         if (wr_sc) begin
            request_mask_q       <= reg_wdata_i[`KBU_BIT_MASK];
            sensitivity_select_q <= reg_wdata_i[`KBU_BIT_SENS];
         end
         if (wr_brk) begin
            break_clear_enable_q <= reg_wdata_i[`KBU_BIT_BCLR_EN];
         end
         pending_q       <= pending_d;
         ack_seen_q      <= ack_seen_d;
         all_high_prev_q <= !any_low;
      end
   end

   // ==========================================================
   // Outputs, all registered; no clock gating so stop and wait see it
   always @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         key_pullup_en_o <= 8'h00;
         key_dir_out_o   <= 8'h00;
         kbd_irq_o       <= 1'b0;
         wake_o          <= 1'b0;
      end else begin
         key_pullup_en_o <= pin_enable_q;
         key_dir_out_o   <= port_a_direction_i & ~pin_enable_q;
         kbd_irq_o       <= pending_q && !request_mask_q;
         wake_o          <= pending_q && !request_mask_q;
      end
   end

   // ==========================================================
   // Read data, valid one cycle after the strobe
   always @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         reg_rdata_o <= 8'h00;
      end else if (reg_rd_i) begin
         case (reg_addr_i)
            `KBU_OFF_STATUS_CTRL: begin
               // Ack bit always reads zero
               reg_rdata_o <= {4'h0, pending_q, 1'b0,
                               request_mask_q, sensitivity_select_q};
            end
            `KBU_OFF_PIN_ENABLE: begin
               reg_rdata_o <= pin_enable_q;
            end
            `KBU_OFF_BREAK_CTRL: begin
               reg_rdata_o <= {7'h00, break_clear_enable_q};
            end
            default: begin
               reg_rdata_o <= 8'h00;
            end
         endcase
      end else begin
         reg_rdata_o <= 8'h00;
      end
   end

endmodule

`default_nettype wire

// file: testbench/kbu_key_pad.sv
`default_nettype none
// ==========
// Key pad: a pressed key pulls low, a released key rests on its pullup
module kbu_key_pad (
   input  wire logic       clk_sys_i,
   input  wire logic [7:0] pullup_en_i,
   input  wire logic [7:0] press_i,
   output var  logic [7:0] key_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] float_q = 8'h55;
   // A loose pin with no pullup toggles every cycle, so it reads high only every other cycle
   always @(posedge clk_sys_i) float_q <= ~float_q;
   assign key_o = ~press_i & (pullup_en_i | float_q);
endmodule
`default_nettype wire

// file: testbench/kbu_chk_assertions.sv
`default_nettype none
// ==========
// Port checker
module kbu_chk (
   input wire logic       clk_sys_i, rst_n_i, reg_wr_i, reg_rd_i, vector_fetch_ack_i,
   input wire logic       break_state_i, kbd_irq_o, wake_o,
   input wire logic [4:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i, reg_rdata_o, key_inputs_i, port_a_direction_i,
   input wire logic [7:0] key_pullup_en_o, key_dir_out_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);
   wire rs = reg_rd_i && reg_addr_i == 5'h16;
   // Three high cycles flush the synchroniser, so no fall races the ack
   sequence s_quiet; (key_inputs_i == 8'hFF)[*3]; endsequence
   sequence s_ack; vector_fetch_ack_i || (reg_wr_i && reg_addr_i == 5'h16
      && reg_wdata_i[2] && !break_state_i); endsequence
   property p_rst; disable iff (1'b0) !rst_n_i |=> !kbd_irq_o; endproperty
   a_rst: assert property (p_rst) else $error("irq after reset");
   property p_wake; wake_o == kbd_irq_o; endproperty
   a_wake: assert property (p_wake) else $error("wake");
   property p_ackrd; rs |=> (reg_rdata_o & 8'hF4) == 8'h00; endproperty
   a_ackrd: assert property (p_ackrd) else $error("status bits");
   property p_flag; rs |=> kbd_irq_o == (reg_rdata_o[3] && !reg_rdata_o[1]); endproperty
   a_flag: assert property (p_flag) else $error("flag vs irq");
   property p_puval; reg_wr_i && reg_addr_i == 5'h17
      |-> ##2 key_pullup_en_o == $past(reg_wdata_i, 2); endproperty
   a_puval: assert property (p_puval) else $error("pullup");
   property p_puhold; $changed(key_pullup_en_o)
      |-> $past(reg_wr_i, 2) && $past(reg_addr_i, 2) == 5'h17; endproperty
   a_puhold: assert property (p_puhold) else $error("pullup moved");
   property p_dir; $past(rst_n_i) && $past(rst_n_i, 2)
      |-> key_dir_out_o == ($past(port_a_direction_i) & ~key_pullup_en_o); endproperty
   a_dir: assert property (p_dir) else $error("direction");
   property p_ackclr; s_quiet ##0 s_ack |-> ##2 !kbd_irq_o; endproperty
   a_ackclr: assert property (p_ackclr) else $error("ack kept irq");
endmodule
bind kbu_keyboard_unit kbu_chk u_chk (.*);
`default_nettype wire

// file: testbench/tb_top.sv
`default_nettype none
// ==========
// Bench
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic       clk = 0, rst = 0, wr = 0, rd = 0, vf = 0, brk = 0, irq, wake;
   logic [4:0] adr = 0;
   logic [7:0] wd = 0, dir = 0, prs = 0, rdat, keys, pu, dout;
   int         error_cnt = 0, checks_done = 0, cyc = 0;
   kbu_keyboard_unit u_dut (.clk_sys_i(clk), .rst_n_i(rst), .reg_addr_i(adr),
      .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat), .key_inputs_i(keys),
      .port_a_direction_i(dir), .key_pullup_en_o(pu), .key_dir_out_o(dout),
      .vector_fetch_ack_i(vf), .break_state_i(brk), .kbd_irq_o(irq), .wake_o(wake));
   kbu_key_pad u_pad (.clk_sys_i(clk), .pullup_en_i(pu), .press_i(prs), .key_o(keys));
   initial forever #50 clk = ~clk;
   // The run needs about 120 cycles; far beyond that it hangs
   always @(posedge clk) if (++cyc == 1000) begin error_cnt++; final_report(); end
   task automatic chk(input logic [7:0] s, e);
      checks_done++;
      if (s !== e) begin error_cnt++; $display("ERROR %0t got %h want %h", $time, s, e); end
   endtask
   task automatic wt(input int n); repeat (n) @(posedge clk); endtask
   // One strobe cycle, then an idle one; read data are taken in the cycle after
   task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
      adr <= a; wd <= d; wr <= w; rd <= !w; wt(1); wr <= 0; rd <= 0; wt(1);
      if (!w) chk(rdat, d);
   endtask
   task automatic pv; vf <= 1; wt(1); vf <= 0; wt(1); endtask
   task automatic pk(input logic [7:0] p); prs <= p; wt(5); endtask
   task automatic final_report;
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // Main sequence
   initial begin
      void'($urandom(89));
      dir <= 8'($urandom());
      wt(3); rst <= 1; wt(1);
      bus(0, 5'h16, 8'h00); bus(0, 5'h17, 8'h00); bus(0, 5'h1F, 8'h00);
      bus(1, 5'h16, 8'h02); bus(1, 5'h17, 8'hFF); wt(6);
      bus(1, 5'h16, 8'h06); bus(1, 5'h16, 8'h00);
      bus(0, 5'h17, 8'hFF); bus(0, 5'h16, 8'h00);
      $display("init done");
      pk(8'h01); bus(0, 5'h16, 8'h08);
      chk(8'(irq), 8'h01);
      prs <= 8'h03; pv(); wt(4); bus(0, 5'h16, 8'h00);
      pk(8'h00); pk(8'h02); bus(0, 5'h16, 8'h08);
      bus(1, 5'h16, 8'h04); bus(0, 5'h16, 8'h00);
      $display("edge done");
      pk(8'h00); bus(1, 5'h16, 8'h01); pk(8'h01); pv(); bus(0, 5'h16, 8'h09);
      pk(8'h00); bus(0, 5'h16, 8'h01);
      $display("level done");
      bus(1, 5'h16, 8'h02); pk(8'h01); bus(0, 5'h16, 8'h0A);
      chk(8'(irq), 8'h00);
      bus(1, 5'h18, 8'h00); brk <= 1; bus(1, 5'h16, 8'h06); brk <= 0;
      bus(0, 5'h16, 8'h0A);
      bus(1, 5'h16, 8'h06); bus(0, 5'h16, 8'h02);
      bus(1, 5'h16, 8'h01); pk(8'h00); pk(8'h01); bus(0, 5'h16, 8'h09);
      rst <= 0; wt(2); rst <= 1; wt(1);
      bus(0, 5'h16, 8'h00);
      $display("mask and reset done");
      final_report();
   end
endmodule
`default_nettype wire
